// ===== rtl/tcu_capture.sv
// Notes on behaviour
// R01: two channels, 256 samples each
// R02: sample interval 400 us to 26.2 s
// R03: one interval serves both channels
// R04: host picks each channel's variable and drive
// R05: level trigger on rising or falling crossing
// R06: trigger when chosen profile starts
// R07: trigger when chosen flag changes state
// R08: host trigger starts on start command
// R09: normal mode stores from trigger, no delay
// R10: pretrigger percentage sets pre-trigger share
// R11: delayed mode waits programmed delay first
// R12: multishot holds recording until release
// R13: multishot only without host trigger, pretrigger
// R14: armed unit waits trigger, then records
// R15: finished recording raises data ready
// R16: release sends latest finished multishot recording
// R17: release mid-recording waits for its end
// R18: pretrigger plus host: start arms, release triggers
// R19: abort ends armed or running recording
// R20: abort returns idle, drops data, no ready
`timescale 1ns/1ps
`default_nettype none
module tcu_capture #(
    parameter int TICK_CYC = tcu_pkg::BASE_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire tcu_pkg::tcu_cfg_t cfg_i,
    input wire tcu_pkg::tcu_cmd_t cmd_i,
    input wire tcu_pkg::tcu_sample_t ch_i,
    input wire logic [tcu_pkg::DW-1:0] trig_var_i,
    input wire logic prof_start_i,
    input wire logic [7:0] prof_num_i,
    input wire logic flag_i,
    input wire logic [tcu_pkg::AW-1:0] rd_addr_i,
    output tcu_pkg::tcu_sample_t rd_data_o,
    output tcu_pkg::tcu_status_t status_o
);
    import tcu_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE,
        ST_WAIT,
        ST_DELAY,
        ST_REC,
        ST_READY
    } tcu_state_t;

    typedef struct packed {
        tcu_state_t st;
        tcu_cfg_t cfg;
        logic bank;
        logic held_bank;
        logic held_valid;
        logic shot_pend;
        logic [AW-1:0] wr_ptr;
        logic [8:0] cnt;
        logic [AW-1:0] rd_base;
        logic [15:0] dly;
        logic cfg_err;
        logic ready;
    } tcu_cap_st_t;

    function automatic logic cfg_ok(input tcu_cfg_t c);
        cfg_ok = (c.cap != TCU_CAP_NORMAL && c.cap != TCU_CAP_PRE
            && c.cap != TCU_CAP_DELAY) ? 1'b0 :
            !(c.multishot && (c.trig == TCU_TRIG_HOST || c.cap == TCU_CAP_PRE));
    endfunction : cfg_ok

    // share of the 256 slots kept before the trigger; one slot always follows
    function automatic logic [8:0] pre_count(input logic [6:0] pct);
        logic [15:0] n;
        n = ({9'h000, pct} << AW) / PCT_DIV;
        pre_count = (n[8:0] > PRE_MAX) ? PRE_MAX : n[8:0];
    endfunction : pre_count

    tcu_cap_st_t s;
    tcu_cap_st_t next_s;
    tcu_sample_t mem [0:2*DEPTH-1];
    tcu_sample_t rd_q;
    logic we;
    logic base_tick;
    logic sample_tick;
    logic hit;
    logic run;
    logic armed;
    logic busy;
    logic [8:0] pre_n;
    logic last;

    assign busy = s.st inside {ST_PRE, ST_WAIT, ST_DELAY, ST_REC};
    assign run = s.st inside {ST_PRE, ST_DELAY, ST_REC};
    assign armed = s.st == ST_WAIT || (s.st == ST_PRE && s.cnt >= pre_n);
    assign pre_n = pre_count(s.cfg.pre_pct);
    assign last = s.cnt == {1'b0, LAST_IDX};

    tcu_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(run),
        .interval_i(s.cfg.interval),
        .base_o(base_tick),
        .sample_o(sample_tick)
    );

    tcu_trig u_trig (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .arm_i(armed),
        .cfg_i(s.cfg),
        .var_i(trig_var_i),
        .prof_start_i(prof_start_i),
        .prof_num_i(prof_num_i),
        .flag_i(flag_i),
        .host_i(cmd_i.shot && s.cfg.cap == TCU_CAP_PRE),
        .hit_o(hit)
    );

    always_comb begin
        next_s = s;
        we = 1'b0;
        if (cmd_i.abort && busy) begin
            // partial data is dropped and the held copy with it
            next_s.st = ST_IDLE; // R19 R20
            next_s.shot_pend = 1'b0;
            next_s.held_valid = 1'b0;
            next_s.ready = 1'b0; // R20
        end else begin
            unique case (s.st)
                ST_IDLE, ST_READY: begin
                    if (cmd_i.start) begin
                        next_s.ready = 1'b0;
                        next_s.cfg_err = !cfg_ok(cfg_i); // R13
                        if (cfg_ok(cfg_i)) begin
                            next_s.cfg = cfg_i;
                            next_s.cnt = '0;
                            next_s.wr_ptr = '0;
                            next_s.rd_base = '0;
                            next_s.dly = '0;
                            next_s.held_valid = 1'b0;
                            next_s.shot_pend = 1'b0;
                            if (cfg_i.cap == TCU_CAP_PRE) begin
                                next_s.st = ST_PRE; // R18
                            end else if (cfg_i.trig == TCU_TRIG_HOST) begin
                                next_s.st = (cfg_i.cap == TCU_CAP_DELAY) ? // R08
                                    ST_DELAY : ST_REC;
                            end else begin
                                next_s.st = ST_WAIT; // R14
                            end
                        end
                    end
                end
                ST_PRE: begin
                    // the trigger is only taken once the pre share is filled
                    if (hit) begin
                        next_s.st = ST_REC; // R10
                        next_s.cnt = pre_n;
                        next_s.rd_base = s.wr_ptr - pre_n[AW-1:0];
                    end else if (sample_tick) begin
                        we = 1'b1;
                        next_s.wr_ptr = s.wr_ptr + 8'h01;
                        if (s.cnt < pre_n) begin
                            next_s.cnt = s.cnt + 9'h001;
                        end
                    end
                end
                ST_WAIT: begin
                    if (hit) begin
                        next_s.cnt = '0;
                        next_s.wr_ptr = '0;
                        next_s.rd_base = '0;
                        next_s.dly = '0;
                        next_s.st = (s.cfg.cap == TCU_CAP_DELAY) ? // R11
                            ST_DELAY : ST_REC; // R09
                    end
                end
                ST_DELAY: begin
                    if (s.dly >= s.cfg.delay) begin
                        next_s.st = ST_REC; // R11
                    end else if (base_tick) begin
                        next_s.dly = s.dly + 16'h0001;
                    end
                end
                ST_REC: begin
                    if (sample_tick) begin
                        we = 1'b1; // R01
                        next_s.wr_ptr = s.wr_ptr + 8'h01;
                        next_s.cnt = s.cnt + 9'h001;
                        if (last) begin
                            next_s.held_bank = s.bank;
                            if (s.cfg.multishot) begin
                                // rearm: the next recording after a trigger goes into the other bank
                                next_s.held_valid = 1'b1; // R12
                                next_s.bank = !s.bank;
                                if (s.shot_pend || cmd_i.shot) begin
                                    next_s.st = ST_READY; // R17
                                    next_s.ready = 1'b1;
                                    next_s.shot_pend = 1'b0;
                                end else begin
                                    next_s.st = ST_WAIT;
                                end
                            end else begin
                                next_s.st = ST_READY; // R15
                                next_s.ready = 1'b1;
                            end
                        end
                    end
                    if (cmd_i.shot && s.cfg.multishot && !(sample_tick && last)) begin
                        next_s.shot_pend = 1'b1; // R17
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                end
            endcase
            if (s.cfg.multishot && cmd_i.shot
                && (s.st == ST_WAIT || s.st == ST_DELAY)) begin
                if (s.held_valid) begin
                    next_s.st = ST_READY; // R16
                    next_s.ready = 1'b1;
                end else begin
                    next_s.shot_pend = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // buffers carry no reset; readout is one cycle behind the address
    always_ff @(posedge clk_i) begin
        if (we) begin
            mem[{s.bank, s.wr_ptr}] <= ch_i;
        end
        rd_q <= mem[{s.held_bank, s.rd_base + rd_addr_i}];
    end

    assign rd_data_o = rd_q;
    // one driver for the whole status word
    assign status_o = '{ready: s.ready, busy: busy, held: s.held_valid, cfg_err: s.cfg_err};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_last_store;
        s.st == ST_REC && sample_tick && last && !cmd_i.abort;
    endsequence

    sequence s_good_start;
        s.st inside {ST_IDLE, ST_READY} && cmd_i.start && cfg_ok(cfg_i);
    endsequence

    // a start may follow the abort at once, so only ready is held a second cycle
    AST_ABORT_IDLE: assert property (cmd_i.abort && busy |=> // R19
        (s.st == ST_IDLE && !status_o.ready) ##1 !status_o.ready)
        else $error("abort did not return idle");
    AST_BAD_CFG: assert property (s.st == ST_IDLE && cmd_i.start // R13
        && !cfg_ok(cfg_i) |=> s.st == ST_IDLE && status_o.cfg_err)
        else $error("illegal setting accepted");
    AST_HOST_NOW: assert property (s_good_start and // R08
        (cfg_i.trig == TCU_TRIG_HOST && cfg_i.cap == TCU_CAP_NORMAL)
        |=> s.st == ST_REC && s.cnt == 9'h000)
        else $error("host start did not record");
    AST_DONE_READY: assert property (s_last_store ##0 !s.cfg.multishot // R15
        |=> status_o.ready && s.st == ST_READY)
        else $error("ready missing after last sample");
    AST_MULTI_HOLD: assert property (s_last_store ##0 s.cfg.multishot // R12
        && !s.shot_pend && !cmd_i.shot |=> !status_o.ready && status_o.held)
        else $error("multishot data not held");
    AST_SHOT_WAIT: assert property (s.st == ST_REC && cmd_i.shot // R17
        && s.cfg.multishot && !cmd_i.abort && !(sample_tick && last)
        |=> s.shot_pend && !status_o.ready)
        else $error("release did not wait for end");
    AST_PRE_FILL: assert property (s.st == ST_PRE && s.cnt < pre_n // R10
        |=> s.st != ST_REC)
        else $error("trigger taken before pre share filled");
    AST_NORMAL_GO: assert property (s.st == ST_WAIT && hit // R09
        && s.cfg.cap == TCU_CAP_NORMAL && !cmd_i.abort
        |=> s.st == ST_REC && s.wr_ptr == 8'h00)
        else $error("normal mode delayed start");
    AST_DELAY_HOLD: assert property (s.st == ST_DELAY // R11
        && s.dly < s.cfg.delay |=> s.st != ST_REC)
        else $error("recording began before delay end");
    AST_REC_COUNT: assert property (s.st == ST_REC && sample_tick // R01
        && !last && !cmd_i.abort |=> s.cnt == $past(s.cnt) + 9'h001)
        else $error("sample count slipped");
endmodule : tcu_capture
`default_nettype wire

// ===== shared/tcu_pkg.sv
`default_nettype none
package tcu_pkg;
    localparam int DEPTH = 256;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int CLK_NS = 10;
    // one interval step; 16-bit step count reaches 65535 * 400 us = 26.2 s
    localparam int BASE_TICK_NS = 400000;
    localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_NS;
    localparam logic [7:0] LAST_IDX = 8'hFF;
    localparam logic [8:0] PRE_MAX = 9'h0FF;
    localparam logic [15:0] PCT_DIV = 16'h0064;

    typedef enum logic [1:0] {
        TCU_TRIG_LEVEL,
        TCU_TRIG_PROFILE,
        TCU_TRIG_FLAG,
        TCU_TRIG_HOST
    } tcu_trig_t;

    typedef enum logic [1:0] {
        TCU_CAP_NORMAL,
        TCU_CAP_PRE,
        TCU_CAP_DELAY
    } tcu_cap_t;

    typedef struct packed {
        tcu_trig_t trig;
        tcu_cap_t cap;
        logic multishot;
        logic edge_up;
        logic [DW-1:0] threshold;
        logic [7:0] profile;
        logic [6:0] pre_pct;
        logic [15:0] delay;
        logic [15:0] interval;
    } tcu_cfg_t;

    typedef struct packed {
        logic [DW-1:0] a;
        logic [DW-1:0] b;
    } tcu_sample_t;

    typedef struct packed {
        logic start;
        logic shot;
        logic abort;
    } tcu_cmd_t;

    typedef struct packed {
        logic ready;
        logic busy;
        logic held;
        logic cfg_err;
    } tcu_status_t;
endpackage : tcu_pkg
`default_nettype wire

// ===== rtl/tcu_tick.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_tick #(
    parameter int TICK_CYC = tcu_pkg::BASE_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic [15:0] interval_i,
    output logic base_o,
    output logic sample_o
);
    import tcu_pkg::*;

    typedef struct packed {
        logic [31:0] base_cnt;
        logic [15:0] samp_cnt;
        logic base;
        logic samp;
    } tcu_tick_st_t;

    tcu_tick_st_t s;
    tcu_tick_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.base = 1'b0;
        next_s.samp = 1'b0;
        if (!run_i) begin
            next_s.base_cnt = '0;
            next_s.samp_cnt = '0;
        end else if (s.base_cnt == 32'(TICK_CYC - 1)) begin
            next_s.base_cnt = '0;
            next_s.base = 1'b1;
            // one interval shared by both channels; zero acts as one step
            if (s.samp_cnt + 16'h0001 >= interval_i) begin // R02 R03
                next_s.samp_cnt = '0;
                next_s.samp = 1'b1;
            end else begin
                next_s.samp_cnt = s.samp_cnt + 16'h0001;
            end
        end else begin
            next_s.base_cnt = s.base_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign base_o = s.base;
    assign sample_o = s.samp;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    AST_SAMPLE_ON_STEP: assert property (sample_o |-> base_o) // R02
        else $error("sample strobe off a step");
endmodule : tcu_tick
`default_nettype wire

// ===== rtl/tcu_trig.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_trig (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic arm_i,
    input wire tcu_pkg::tcu_cfg_t cfg_i,
    input wire logic [tcu_pkg::DW-1:0] var_i,
    input wire logic prof_start_i,
    input wire logic [7:0] prof_num_i,
    input wire logic flag_i,
    input wire logic host_i,
    output logic hit_o
);
    import tcu_pkg::*;

    typedef struct packed {
        logic [DW-1:0] prev_var;
        logic prev_flag;
        logic primed;
    } tcu_trig_st_t;

    tcu_trig_st_t s;
    tcu_trig_st_t next_s;
    logic above_now;
    logic above_prev;

    assign above_now = $signed(var_i) > $signed(cfg_i.threshold);
    assign above_prev = $signed(s.prev_var) > $signed(cfg_i.threshold);

    always_comb begin
        next_s.prev_var = var_i;
        next_s.prev_flag = flag_i;
        // history is only trusted after one armed cycle
        next_s.primed = arm_i;
        hit_o = 1'b0;
        if (arm_i) begin
            unique case (cfg_i.trig)
                TCU_TRIG_LEVEL: hit_o = s.primed && (cfg_i.edge_up ? // R05
                    (above_now && !above_prev) : (!above_now && above_prev));
                TCU_TRIG_PROFILE: hit_o = prof_start_i && // R06
                    (prof_num_i == cfg_i.profile);
                TCU_TRIG_FLAG: hit_o = s.primed && (flag_i != s.prev_flag); // R07
                TCU_TRIG_HOST: hit_o = host_i; // R18
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    AST_FLAG_EDGE: assert property (arm_i && $past(arm_i) && // R07
        cfg_i.trig == TCU_TRIG_FLAG && flag_i != $past(flag_i) |-> hit_o)
        else $error("flag change missed");
endmodule : tcu_trig
`default_nettype wire

// ===== testbench/tcu_host.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_host (
    input wire logic clk_i,
    input wire tcu_pkg::tcu_sample_t rd_data_i,
    output tcu_pkg::tcu_cmd_t cmd_o,
    output logic [tcu_pkg::AW-1:0] rd_addr_o
);
    import tcu_pkg::*;

    initial begin
        cmd_o = '0;
        rd_addr_o = '0;
    end

    // one-cycle command pulse; an idle cycle always follows so pulses never merge
    task automatic send(input logic st, input logic sh, input logic ab);
        @(posedge clk_i);
        #1;
        cmd_o = '{start: st, shot: sh, abort: ab};
        @(posedge clk_i);
        #1;
        cmd_o = '0;
    endtask : send

    // address one cycle, data taken the next; the address then moves on
    task automatic read(input logic [AW-1:0] k, output tcu_sample_t s);
        @(posedge clk_i);
        #1;
        rd_addr_o = k;
        @(posedge clk_i);
        #1;
        s = rd_data_i;
        rd_addr_o = ~k;
    endtask : read
endmodule : tcu_host
`default_nettype wire

// ===== testbench/two_channel_trace_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
module two_channel_trace_capture_tb;
    import tcu_pkg::*;
    localparam int TK = 4;
    localparam int PRE_N = 128;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    tcu_cfg_t cfg;
    tcu_cmd_t cmd;
    tcu_sample_t ch;
    tcu_sample_t rd;
    tcu_status_t status;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] trig_var = 16'h0000;
    logic prof_start = 1'b0;
    logic [7:0] prof_num = 8'h00;
    logic flag = 1'b0;
    logic [AW-1:0] rd_addr;
    int bad_count = 0;
    int num_checks = 0;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) cnt <= #1 cnt + 16'h0001;
    // host-selected variables: b is the inverse of a so pairing is visible
    assign ch = '{a: cnt, b: ~cnt};

    tcu_capture #(.TICK_CYC(TK)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg), .cmd_i(cmd), .ch_i(ch),
        .trig_var_i(trig_var), .prof_start_i(prof_start), .prof_num_i(prof_num),
        .flag_i(flag), .rd_addr_i(rd_addr), .rd_data_o(rd), .status_o(status)
    );
    tcu_host HOST (.clk_i(clk_i), .rd_data_i(rd), .cmd_o(cmd), .rd_addr_o(rd_addr));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic wait_ready(input int bound);
        int n;
        n = 0;
        while (status.ready !== 1'b1 && n < bound) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= bound) begin
            bad_count++;
            $display("Error ready expected 1 seen 0");
            final_report();
        end
    endtask : wait_ready

    function automatic tcu_cfg_t mk(input tcu_trig_t t, input tcu_cap_t p, input logic m);
        mk = '0;
        mk.trig = t;
        mk.cap = p;
        mk.multishot = m;
        mk.edge_up = 1'b1;
        mk.threshold = 16'h0064;
        mk.profile = 8'h05;
        mk.pre_pct = 7'h32;
        mk.delay = 16'h0003;
        mk.interval = 16'h0001;
    endfunction : mk

    function automatic logic win(input logic [15:0] v, input int lo, input int hi);
        win = (int'(v) >= lo) && (int'(v) <= hi);
    endfunction : win

    task automatic arm(input tcu_cfg_t c);
        cfg = c;
        HOST.send(1'b1, 1'b0, 1'b0);
    endtask : arm

    initial begin
        #400000;
        bad_count++;
        $display("Error watchdog expected done seen running");
        final_report();
    end

    // trigger table: level up, level down, profile, flag, flag with delay
    tcu_trig_t ttab [5] = '{TCU_TRIG_LEVEL, TCU_TRIG_LEVEL, TCU_TRIG_PROFILE,
                            TCU_TRIG_FLAG, TCU_TRIG_FLAG};
    tcu_cfg_t c;
    tcu_sample_t s;
    int tc;
    int prev;

    initial begin
        cfg = mk(TCU_TRIG_HOST, TCU_CAP_NORMAL, 1'b0);
        repeat (4) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        check("status_reset", status, 32'h0);
        for (int iv = 1; iv <= 2; iv++) begin
            c = mk(TCU_TRIG_HOST, TCU_CAP_NORMAL, 1'b0);
            c.interval = 16'(iv);
            tc = cnt;
            arm(c);
            check("busy", status.busy, 1'b1);
            wait_ready(300 * TK * iv);
            check("ready_busy", {status.ready, status.busy}, 2'b10);
            HOST.read(8'h00, s);
            check("host_first", win(s.a, tc + 1, tc + TK * iv + 8), 1'b1);
            prev = s.a;
            for (int k = 1; k < DEPTH; k++) begin
                HOST.read(AW'(k), s);
                check("step", 16'(s.a - prev), TK * iv);
                check("pair", s.b, 16'(~s.a));
                prev = s.a;
            end
        end
        // abort while waiting for a level that never comes, then while recording
        for (int k = 0; k < 2; k++) begin
            arm(mk(k == 0 ? TCU_TRIG_LEVEL : TCU_TRIG_HOST, TCU_CAP_NORMAL, 1'b0));
            repeat (20) @(posedge clk_i);
            #1;
            HOST.send(1'b0, 1'b0, 1'b1);
            check("abort", status, 32'h0);
        end
        // refused settings: multishot with host trigger, with pretrigger, bad mode
        for (int k = 0; k < 3; k++) begin
            c = mk(k == 0 ? TCU_TRIG_HOST : TCU_TRIG_FLAG, TCU_CAP_PRE, k < 2);
            if (k == 2) c.cap = tcu_cap_t'(2'h3);
            if (k == 0) c.cap = TCU_CAP_NORMAL;
            arm(c);
            check("cfg_err", {status.cfg_err, status.busy}, 2'b10);
        end
        for (int t = 0; t < 5; t++) begin
            c = mk(ttab[t], t == 4 ? TCU_CAP_DELAY : TCU_CAP_NORMAL, 1'b0);
            c.edge_up = (t != 1);
            trig_var = (t == 1) ? 16'h00C8 : 16'h0000;
            arm(c);
            check("cfg_clear", status.cfg_err, 1'b0);
            repeat (8) @(posedge clk_i);
            #1;
            prof_num = 8'h06;
            prof_start = 1'b1;
            @(posedge clk_i);
            #1;
            prof_start = 1'b0;
            repeat (4) @(posedge clk_i);
            #1;
            tc = cnt;
            case (t)
                0: trig_var = 16'h00C8;
                1: trig_var = 16'h0000;
                2: begin
                    prof_num = 8'h05;
                    prof_start = 1'b1;
                end
                default: flag = ~flag;
            endcase
            @(posedge clk_i);
            #1;
            prof_start = 1'b0;
            wait_ready(1400);
            HOST.read(8'h00, s);
            if (t == 4) begin
                check("delay_first", win(s.a, tc + 3 * TK, tc + 4 * TK + 8), 1'b1);
            end else begin
                check("trig_first", win(s.a, tc + 1, tc + TK + 8), 1'b1);
            end
        end
        // pretrigger, host trigger: start arms, shot triggers, data follow by themselves
        arm(mk(TCU_TRIG_HOST, TCU_CAP_PRE, 1'b0));
        repeat (TK * 140) @(posedge clk_i);
        #1;
        tc = cnt;
        HOST.send(1'b0, 1'b1, 1'b0);
        wait_ready(1400);
        HOST.read(AW'(PRE_N - 1), s);
        prev = s.a;
        check("pre_last", win(s.a, tc - TK - 2, tc + 2), 1'b1);
        HOST.read(8'h00, s);
        check("pre_oldest", 16'(prev - s.a), TK * (PRE_N - 1));
        HOST.read(AW'(PRE_N), s);
        check("post_first", win(s.a, tc + 1, tc + 2 * TK + 8), 1'b1);
        // multishot: finished recording is held until shot
        arm(mk(TCU_TRIG_FLAG, TCU_CAP_NORMAL, 1'b1));
        repeat (8) @(posedge clk_i);
        #1;
        tc = cnt;
        flag = ~flag;
        repeat (TK * 270) @(posedge clk_i);
        #1;
        check("ms_held", {status.ready, status.held}, 2'b01);
        HOST.send(1'b0, 1'b1, 1'b0);
        @(posedge clk_i);
        #1;
        check("ms_shot", status.ready, 1'b1);
        HOST.read(8'h00, s);
        check("ms_data", win(s.a, tc + 1, tc + TK + 8), 1'b1);
        // shot in mid-recording waits for the recording to end
        arm(mk(TCU_TRIG_FLAG, TCU_CAP_NORMAL, 1'b1));
        repeat (8) @(posedge clk_i);
        #1;
        tc = cnt;
        flag = ~flag;
        repeat (40) @(posedge clk_i);
        #1;
        HOST.send(1'b0, 1'b1, 1'b0);
        check("ms_early", status.ready, 1'b0);
        wait_ready(1400);
        check("ms_full", int'(cnt) - tc >= TK * DEPTH, 1'b1);
        final_report();
    end
endmodule : two_channel_trace_capture_tb
`default_nettype wire
